// file: hw/ndid_regs.sv
// Node identity and PHY register access block
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module ndid_regs (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire ndid_pkg::ndid_av_req_s av_in,
  output logic [31:0] av_readdata_out,
  output logic av_waitrequest_out,
  input wire ndid_pkg::ndid_phy_in_s phy_in,
  output logic phy_lreq_out,
  output logic [15:0] node_id_out,
  output logic irq_out
);
  import ndid_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : be_mask

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction : hit

  // ****************************************
  // State
  // ****************************************
  logic node_ident_ok_flag, next_node_ident_ok_flag;
  logic root_flag, next_root_flag;
  logic cable_power_good, next_cable_power_good;
  logic [SEG_W-1:0] bus_segment_id, next_bus_segment_id;
  logic [IDX_W-1:0] phy_assigned_index, next_phy_assigned_index;
  logic phy_read_complete, next_phy_read_complete;
  logic [3:0] phy_returned_reg_index, next_phy_returned_reg_index;
  logic [7:0] phy_returned_value, next_phy_returned_value;
  logic phy_read_request, next_phy_read_request;
  logic phy_write_request, next_phy_write_request;
  logic [3:0] phy_target_reg, next_phy_target_reg;
  logic [7:0] phy_write_value, next_phy_write_value;
  logic [IRQ_W-1:0] irq_status, next_irq_status;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_av_readdata;
  logic next_av_waitrequest;
  logic next_irq;
  logic [15:0] next_node_id;
  ndid_tx_e tx_state, next_tx_state;
  logic [LR_FRAME_W-1:0] tx_shift, next_tx_shift;
  logic [4:0] tx_cnt, next_tx_cnt;
  logic next_phy_lreq;
  logic [15:0] st_shift, next_st_shift;
  logic [3:0] st_cnt, next_st_cnt;

  // ****************************************
  // Bus decode and status receive terms
  // ****************************************
  logic wr_go, rd_go, st_active, st_end, st_done, st_busrst, st_reg0;
  logic [15:0] st_word;
  logic [31:0] wmask, wval, node_word, pa_word;
  logic tx_start, tx_last;

  always_comb begin
    wr_go = av_in.write && !av_waitrequest_out;
    rd_go = av_in.read && av_waitrequest_out;
    wmask = be_mask(av_in.byteenable);
    st_active = phy_in.ctl == CTL_STATUS;
    st_word = {phy_in.data, st_shift[15:2]};
    st_end = !st_active && (st_cnt != 4'h0);
    st_done = st_active && (st_cnt == ST_PAIRS - 4'h1);
    st_busrst = (st_done && st_word[ST_BUSRST_BIT]) ||
                (st_end && st_cnt >= ST_FLAG_PAIRS &&
                 st_shift[16 - 2*int'(st_cnt) + ST_BUSRST_BIT]);
    st_reg0 = st_done && st_word[7:4] == PHY_REG0;
    tx_start = tx_state == TX_IDLE && (phy_read_request || phy_write_request);
    tx_last = tx_state == TX_SEND && tx_cnt == 5'h00;
    node_word = '0;
    node_word[ID_VALID_BIT] = node_ident_ok_flag;
    node_word[ID_ROOT_BIT] = root_flag;
    node_word[ID_CPS_BIT] = cable_power_good;
    node_word[15:0] = {bus_segment_id, phy_assigned_index};
    pa_word = {phy_read_complete, 3'h0, phy_returned_reg_index,
               phy_returned_value, phy_read_request, phy_write_request,
               2'h0, phy_target_reg, phy_write_value};
    wval = '0;
    if (hit(av_in.address, NODE_IDENTITY_OFS)) begin
      wval = node_word;
    end else if (hit(av_in.address, PHY_REGISTER_ACCESS_OFS)) begin
      wval = pa_word;
    end else if (hit(av_in.address, IRQ_STATUS_OFS)) begin
      wval = 32'(irq_status);
    end else if (hit(av_in.address, IRQ_MASK_OFS)) begin
      wval = 32'(irq_mask);
    end
  end

  // ****************************************
  // Bus slave, one wait cycle per access
  // ****************************************
  always_comb begin
    next_av_waitrequest = 1'b1;
    next_av_readdata = av_readdata_out;
    if ((av_in.read || av_in.write) && av_waitrequest_out) begin
      next_av_waitrequest = 1'b0;
    end
    if (rd_go) begin
      next_av_readdata = wval;
    end
  end

  // ****************************************
  // Status receive from the PHY
  // ****************************************
  always_comb begin
    next_st_shift = st_shift;
    next_st_cnt = st_cnt;
    if (st_active) begin
      next_st_shift = st_word;
      next_st_cnt = st_done ? 4'h0 : st_cnt + 4'h1;
    end else begin
      next_st_cnt = 4'h0;
    end
  end

  // ****************************************
  // Link request sender
  // ****************************************
  always_comb begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_cnt = tx_cnt;
    next_phy_lreq = 1'b0;
    unique case (tx_state)
      TX_IDLE: begin
        if (tx_start) begin
          next_tx_state = TX_SEND;
          if (phy_read_request) begin
            next_tx_shift = {1'b1, LR_TYPE_READ, phy_target_reg, 1'b0,
                             8'h00};
            next_tx_cnt = LR_LEN_READ - 5'h01;
          end else begin
            next_tx_shift = {1'b1, LR_TYPE_WRITE, phy_target_reg,
                             phy_write_value, 1'b0};
            next_tx_cnt = LR_LEN_WRITE - 5'h01;
          end
        end
      end
      TX_SEND: begin
        next_phy_lreq = tx_shift[LR_FRAME_W-1];
        next_tx_shift = {tx_shift[LR_FRAME_W-2:0], 1'b0};
        next_tx_cnt = tx_cnt - 5'h01;
        if (tx_last) begin
          next_phy_lreq = 1'b0;
          next_tx_cnt = 5'h00;
          next_tx_state = TX_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    logic [31:0] d;
    logic [IRQ_W-1:0] ev;
    d = wmask & av_in.writedata;
    ev = '0;
    next_node_ident_ok_flag = node_ident_ok_flag;
    next_root_flag = root_flag;
    next_cable_power_good = cable_power_good;
    next_bus_segment_id = bus_segment_id;
    next_phy_assigned_index = phy_assigned_index;
    next_phy_read_complete = phy_read_complete;
    next_phy_returned_reg_index = phy_returned_reg_index;
    next_phy_returned_value = phy_returned_value;
    next_phy_read_request = phy_read_request;
    next_phy_write_request = phy_write_request;
    next_phy_target_reg = phy_target_reg;
    next_phy_write_value = phy_write_value;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (wr_go && hit(av_in.address, NODE_IDENTITY_OFS)) begin
      next_bus_segment_id = (bus_segment_id & ~wmask[15:6]) |
                            d[15:6];
    end
    if (tx_last) begin
      next_phy_read_request = 1'b0;
      next_phy_write_request = 1'b0;
    end
    if (wr_go && hit(av_in.address, PHY_REGISTER_ACCESS_OFS)) begin
      next_phy_target_reg = (phy_target_reg & ~wmask[11:8]) | d[11:8];
      next_phy_write_value = (phy_write_value & ~wmask[7:0]) | d[7:0];
      if (d[PA_RD_BIT] || d[PA_WR_BIT]) begin
        next_phy_read_complete = 1'b0;
        next_phy_read_request = d[PA_RD_BIT];
        next_phy_write_request = d[PA_WR_BIT];
      end
    end
    if (wr_go && hit(av_in.address, IRQ_MASK_OFS)) begin
      next_irq_mask = (irq_mask & ~wmask[IRQ_W-1:0]) | d[IRQ_W-1:0];
    end
    if (wr_go && hit(av_in.address, IRQ_STATUS_OFS)) begin
      next_irq_status = irq_status & ~d[IRQ_W-1:0];
    end
    if (st_done) begin
      next_phy_read_complete = 1'b1;
      next_phy_returned_reg_index = st_word[7:4];
      next_phy_returned_value = st_word[15:8];
    end
    if (st_busrst) begin
      next_node_ident_ok_flag = 1'b0;
    end
    if (st_reg0) begin
      next_phy_assigned_index = st_word[15:10];
      next_root_flag = st_word[9];
      next_cable_power_good = st_word[8];
      next_node_ident_ok_flag = !st_word[ST_BUSRST_BIT];
    end
    ev[IRQ_DONE] = st_done;
    ev[IRQ_BUSRST] = st_busrst;
    ev[IRQ_VALID] = next_node_ident_ok_flag && !node_ident_ok_flag;
    next_irq_status = next_irq_status | ev;
    next_irq = |(next_irq_status & next_irq_mask);
    next_node_id = {next_bus_segment_id, next_phy_assigned_index};
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      av_readdata_out <= 32'h0000_0000;
      av_waitrequest_out <= 1'b1;
      node_ident_ok_flag <= 1'b0;
      root_flag <= 1'b0;
      cable_power_good <= 1'b0;
      bus_segment_id <= SEG_RESET;
      phy_assigned_index <= '0;
      {phy_read_complete, phy_returned_reg_index, phy_returned_value,
       phy_read_request, phy_write_request, phy_target_reg,
       phy_write_value} <= {PA_RESET[31], PA_RESET[27:14],
                            PA_RESET[11:0]};
      irq_status <= '0;
      irq_mask <= '0;
      irq_out <= 1'b0;
      node_id_out <= {SEG_RESET, 6'h00};
      tx_state <= TX_IDLE;
      tx_shift <= '0;
      tx_cnt <= 5'h00;
      phy_lreq_out <= 1'b0;
      st_shift <= 16'h0000;
      st_cnt <= 4'h0;
    end else if (ce_in) begin
      av_readdata_out <= next_av_readdata;
      av_waitrequest_out <= next_av_waitrequest;
      node_ident_ok_flag <= next_node_ident_ok_flag;
      root_flag <= next_root_flag;
      cable_power_good <= next_cable_power_good;
      bus_segment_id <= next_bus_segment_id;
      phy_assigned_index <= next_phy_assigned_index;
      phy_read_complete <= next_phy_read_complete;
      phy_returned_reg_index <= next_phy_returned_reg_index;
      phy_returned_value <= next_phy_returned_value;
      phy_read_request <= next_phy_read_request;
      phy_write_request <= next_phy_write_request;
      phy_target_reg <= next_phy_target_reg;
      phy_write_value <= next_phy_write_value;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq_out <= next_irq;
      node_id_out <= next_node_id;
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_cnt <= next_tx_cnt;
      phy_lreq_out <= next_phy_lreq;
      st_shift <= next_st_shift;
      st_cnt <= next_st_cnt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_seg_after_reset: assert property (
    $fell(reset_in) |-> bus_segment_id == SEG_RESET)
    else $error("segment not all ones after reset");
  a_done_cleared: assert property (
    ce_in && wr_go && hit(av_in.address, PHY_REGISTER_ACCESS_OFS) &&
    (av_in.writedata[PA_RD_BIT] || av_in.writedata[PA_WR_BIT]) &&
    av_in.byteenable[1] && !st_done |=> !phy_read_complete)
    else $error("complete flag not cleared by request");
  a_done_set: assert property (
    ce_in && st_done |=> phy_read_complete)
    else $error("complete flag not set by status");
  a_addr_capture: assert property (
    ce_in && st_done |=> phy_returned_reg_index == $past(st_word[7:4]))
    else $error("returned address not captured");
  a_data_capture: assert property (
    ce_in && st_done |=> phy_returned_value == $past(st_word[15:8]))
    else $error("returned value not captured");
  a_req_cleared: assert property (
    ce_in && tx_last && !wr_go |=> !phy_read_request && !phy_write_request)
    else $error("request bit not cleared after send");
  a_valid_clear: assert property (
    ce_in && st_busrst && !st_reg0 |=> !node_ident_ok_flag)
    else $error("valid flag survives bus reset");
  a_index_load: assert property (
    ce_in && st_reg0 |=> phy_assigned_index == $past(st_word[15:10]) &&
    root_flag == $past(st_word[9]) && cable_power_good == $past(st_word[8]))
    else $error("identity not loaded from PHY register 0");
  a_lreq_start: assert property (
    ce_in && tx_start ##1 ce_in |=> phy_lreq_out)
    else $error("link request lacks start bit");
  a_ident_resv: assert property (
    ce_in && rd_go && hit(av_in.address, NODE_IDENTITY_OFS) |=>
    av_readdata_out[29:28] == 2'h0 && av_readdata_out[26:16] == 11'h000 &&
    av_readdata_out[15:0] == $past(node_id_out))
    else $error("identity read word wrong");
  a_ack_single: assert property (
    !av_waitrequest_out |=> av_waitrequest_out)
    else $error("waitrequest low for more than one cycle");

  c_read_done: cover property (ce_in && st_done && st_word[7:4] != PHY_REG0);
  c_new_index: cover property (ce_in && st_reg0);
  c_write_sent: cover property (tx_last && phy_write_request);
  c_bus_reset: cover property (ce_in && st_busrst);
endmodule : ndid_regs

// file: hw/ndid_pkg.sv
// Package with register map, fields, link codes and carrier types
package ndid_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] NODE_IDENTITY_OFS = 12'h0E8;
  localparam logic [11:0] PHY_REGISTER_ACCESS_OFS = 12'h0EC;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h1F0;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h1F4;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int ID_VALID_BIT = 31;
  localparam int ID_ROOT_BIT = 30;
  localparam int ID_CPS_BIT = 27;
  localparam int ID_SEG_LSB = 6;
  localparam int SEG_W = 10;
  localparam int IDX_W = 6;
  localparam logic [9:0] SEG_RESET = 10'h3FF;
  localparam int PA_DONE_BIT = 31;
  localparam int PA_RADDR_LSB = 24;
  localparam int PA_RDATA_LSB = 16;
  localparam int PA_RD_BIT = 15;
  localparam int PA_WR_BIT = 14;
  localparam int PA_TADDR_LSB = 8;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BUSRST = 1;
  localparam int IRQ_VALID = 2;
  localparam logic [31:0] PA_RESET = 32'h0000_0000;
  // ****************************************
  // Link request and status transfer
  // ****************************************
  localparam logic [2:0] LR_TYPE_READ = 3'h4;
  localparam logic [2:0] LR_TYPE_WRITE = 3'h5;
  localparam int LR_FRAME_W = 17;
  localparam logic [4:0] LR_LEN_READ = 5'h09;
  localparam logic [4:0] LR_LEN_WRITE = 5'h11;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [3:0] ST_PAIRS = 4'h8;
  localparam logic [3:0] ST_FLAG_PAIRS = 4'h2;
  localparam int ST_BUSRST_BIT = 2;
  localparam logic [3:0] PHY_REG0 = 4'h0;
  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [11:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ndid_av_req_s;
  typedef struct packed {
    logic [1:0] ctl;
    logic [1:0] data;
  } ndid_phy_in_s;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } ndid_tx_e;
endpackage : ndid_pkg

// file: dv/ndid_phy_model.sv
// Behavioural PHY model for the link request and status lines
`timescale 1ns/1ps
module ndid_phy_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic lreq_in,
  input wire logic bus_reset_in,
  input wire logic [7:0] reg0_in,
  output ndid_pkg::ndid_phy_in_s phy_out
);
  import ndid_pkg::*;
  logic [7:0] regs [16];
  logic [15:0] sr;
  logic [4:0] cnt;
  logic [15:0] rep;
  logic [3:0] rp;
  always @(posedge clk_in) begin
    if (reset_in) begin
      phy_out <= '0;
      cnt <= 5'h00;
      rp <= 4'h0;
    end else begin
      if (rp != 4'h0) begin
        phy_out.ctl <= CTL_STATUS;
        phy_out.data <= rep[1:0];
        rep <= rep >> 2;
        rp <= rp - 4'h1;
      end else begin
        phy_out.ctl <= 2'h0;
        phy_out.data <= ~phy_out.data;
      end
      if (bus_reset_in) begin
        rep <= 16'h0004;
        rp <= ST_FLAG_PAIRS;
      end
      if (cnt == 5'h00) begin
        sr <= {15'h0000, lreq_in};
        cnt <= {4'h0, lreq_in};
      end else begin
        sr <= {sr[14:0], lreq_in};
        cnt <= cnt + 5'h01;
        if (cnt == 5'h08 && sr[6:4] == LR_TYPE_READ) begin
          rep <= {(sr[3:0] == PHY_REG0) ? reg0_in : regs[sr[3:0]],
                  sr[3:0], 4'h0};
          rp <= ST_PAIRS;
          cnt <= 5'h00;
        end
        if (cnt == 5'h10) begin
          regs[sr[11:8]] <= sr[7:0];
          cnt <= 5'h00;
        end
      end
    end
  end
endmodule : ndid_phy_model

// file: dv/testbench.sv
// Self-checking bench for the node identity and PHY access block
`timescale 1ns/1ps
module testbench;
  import ndid_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  ndid_av_req_s av = '0;
  logic [31:0] av_readdata_out;
  logic av_waitrequest_out;
  ndid_phy_in_s phy;
  logic phy_lreq_out;
  logic [15:0] node_id_out;
  logic irq_out;
  logic bus_reset = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg0 = 8'h00;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rd;
  always #50 clk_in = ~clk_in;
  ndid_regs ndid_regs_inst (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce),
    .av_in(av),
    .av_readdata_out(av_readdata_out),
    .av_waitrequest_out(av_waitrequest_out),
    .phy_in(phy),
    .phy_lreq_out(phy_lreq_out),
    .node_id_out(node_id_out),
    .irq_out(irq_out)
  );
  ndid_phy_model ndid_phy_model_inst (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .lreq_in(phy_lreq_out),
    .bus_reset_in(bus_reset),
    .reg0_in(reg0),
    .phy_out(phy)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task finish_test;
    $display("mismatches %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task av_go(input logic [11:0] a, input logic wr, input logic [31:0] d);
    av.address <= a;
    av.write <= wr;
    av.read <= ~wr;
    av.writedata <= d;
    av.byteenable <= 4'hF;
    @(posedge clk_in);
    while (av_waitrequest_out !== 1'b0) begin
      @(posedge clk_in);
    end
    rd = av_readdata_out;
    av.read <= 1'b0;
    av.write <= 1'b0;
    @(posedge clk_in);
  endtask : av_go
  task wait_bit(input logic [11:0] a, input int b, input logic v);
    int n;
    n = 0;
    rd = {32{~v}};
    while (rd[b] !== v && n < 60) begin
      av_go(a, 1'b0, 32'h0);
      n++;
    end
    if (n == 60) begin
      n_errors++;
      $display("wrong value poll bit %0d expected %0b seen %0b", b, v, rd[b]);
    end
  endtask : wait_bit
  task t_freeze;
    ce <= 1'b0;
    av.address <= NODE_IDENTITY_OFS;
    av.read <= 1'b1;
    av.byteenable <= 4'hF;
    repeat (4) begin
      @(posedge clk_in);
      chk("frozen_wait", 32'h1, {31'h0, av_waitrequest_out});
    end
    ce <= 1'b1;
    av.read <= 1'b0;
    @(posedge clk_in);
    chk("frozen_id", 32'hFFC0, {16'h0, node_id_out});
  endtask : t_freeze
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    av_go(NODE_IDENTITY_OFS, 1'b0, 32'h0);
    chk("node_identity", 32'h0000_FFC0, rd);
    chk("node_id_out", 32'hFFC0, {16'h0, node_id_out});
    av_go(PHY_REGISTER_ACCESS_OFS, 1'b0, 32'h0);
    chk("phy_access", PA_RESET, rd);
    av_go(12'h0F0, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask : t_reset
  task t_segment;
    av_go(NODE_IDENTITY_OFS, 1'b1, 32'hFFFF_5555);
    av_go(NODE_IDENTITY_OFS, 1'b0, 32'h0);
    chk("node_identity", 32'h0000_5540, rd);
    chk("node_id_out", 32'h5540, {16'h0, node_id_out});
    av_go(PHY_REGISTER_ACCESS_OFS, 1'b1, 32'h7000_3000);
    av_go(PHY_REGISTER_ACCESS_OFS, 1'b0, 32'h0);
    chk("phy_reserved", 32'h0, rd);
  endtask : t_segment
  task t_self_id;
    reg0 <= 8'h56; // Index 21, not 63
    av_go(IRQ_MASK_OFS, 1'b1, 32'h7);
    av_go(PHY_REGISTER_ACCESS_OFS, 1'b1, 32'h0000_80AB);
    wait_bit(PHY_REGISTER_ACCESS_OFS, 31, 1'b1);
    chk("phy_access", 32'h8056_00AB, rd);
    chk("irq_out", 32'h1, {31'h0, irq_out});
    av_go(NODE_IDENTITY_OFS, 1'b0, 32'h0);
    chk("node_identity", 32'hC000_5555, rd);
    chk("node_id_out", 32'h5555, {16'h0, node_id_out});
    av_go(IRQ_STATUS_OFS, 1'b0, 32'h0);
    chk("irq_status", 32'h5, rd);
    av_go(IRQ_STATUS_OFS, 1'b1, 32'h5);
    av_go(IRQ_STATUS_OFS, 1'b0, 32'h0);
    chk("irq_cleared", 32'h0, rd);
    chk("irq_out", 32'h0, {31'h0, irq_out});
  endtask : t_self_id
  task t_write;
    av_go(PHY_REGISTER_ACCESS_OFS, 1'b1, 32'h0000_43C9);
    av_go(PHY_REGISTER_ACCESS_OFS, 1'b0, 32'h0);
    chk("done_cleared", 32'h0, rd & 32'h8000_0000);
    wait_bit(PHY_REGISTER_ACCESS_OFS, 14, 1'b0);
    chk("phy_reg3", 32'hC9, {24'h0, ndid_phy_model_inst.regs[3]});
    av_go(PHY_REGISTER_ACCESS_OFS, 1'b1, 32'h0000_8300);
    wait_bit(PHY_REGISTER_ACCESS_OFS, 31, 1'b1);
    chk("phy_access", 32'h83C9_0300, rd);
    av_go(IRQ_STATUS_OFS, 1'b1, 32'h7);
  endtask : t_write
  task t_bus_reset;
    av_go(IRQ_MASK_OFS, 1'b1, 32'h0);
    bus_reset <= 1'b1;
    @(posedge clk_in);
    bus_reset <= 1'b0;
    wait_bit(IRQ_STATUS_OFS, IRQ_BUSRST, 1'b1);
    chk("irq_masked", 32'h0, {31'h0, irq_out});
    av_go(NODE_IDENTITY_OFS, 1'b0, 32'h0);
    chk("valid_cleared", 32'h0, rd & 32'h8000_0000);
    av_go(IRQ_MASK_OFS, 1'b1, 32'h2);
    @(posedge clk_in);
    chk("irq_unmasked", 32'h1, {31'h0, irq_out});
    av_go(IRQ_STATUS_OFS, 1'b1, 32'h2);
    @(posedge clk_in);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    reg0 <= 8'h57;
    av_go(PHY_REGISTER_ACCESS_OFS, 1'b1, 32'h0000_8000);
    wait_bit(PHY_REGISTER_ACCESS_OFS, 31, 1'b1);
    av_go(NODE_IDENTITY_OFS, 1'b0, 32'h0);
    chk("node_identity", 32'hC800_5555, rd);
  endtask : t_bus_reset
  // ****************************************
  // Main sequence and timeout
  // ****************************************
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset;
    t_freeze;
    t_segment;
    t_self_id;
    t_write;
    t_bus_reset;
    finish_test;
  end
endmodule : testbench
